// ---- pkg/drp_pkg.sv ----
// constants for the read / auto-precharge timing block of a ddr2 device
// Operation
// - read-to-precharge counts from last prefetch edge: AL, or AL+2 for burst 8.
// - address bit 10 high on READ selects auto precharge; low keeps row open.
// - auto precharge nominally starts AL+BL/2 clocks after the READ command.
// - internal precharge waits until row-active and read-to-precharge times are met.
// - row precharge time counts from the real start of the internal precharge.
// - internal precharge never starts before two clocks after the last prefetch.
// - auto-precharge READ to one bank while other banks keep operating.
// - lower byte strobe times data bits 0-7, upper strobe bits 8-15.
// - read latency is AL plus CL clocks; elements follow on successive edges.
package drp_pkg;

  // ==========================================================================
  // geometry
  localparam int NUM_BANKS = 8;
  localparam int BA_W = 3;
  localparam int ADDR_W = 14;
  localparam int DQ_W = 16;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int PIPE_DEPTH = 16;

  // ==========================================================================
  // burst figures in link clocks
  localparam logic [3:0] HALF_BL4 = 4'h2;
  localparam logic [3:0] HALF_BL8 = 4'h4;
  localparam logic [3:0] PREF_EXTRA_BL8 = 4'h2;

  // ==========================================================================
  // analog times in ps; values are plain defaults
  localparam int CORE_CLK_PS = 10000;
  localparam int T_RAS_PS = 40000;
  localparam int T_RTP_PS = 7500;
  localparam int T_RP_PS = 15000;

  // least times round up to whole core cycles
  localparam logic [7:0] RAS_CYC =
    8'((T_RAS_PS + CORE_CLK_PS - 1) / CORE_CLK_PS);
  localparam logic [7:0] RTP_CYC =
    8'((T_RTP_PS + CORE_CLK_PS - 1) / CORE_CLK_PS);
  localparam logic [7:0] RP_CYC =
    8'((T_RP_PS + CORE_CLK_PS - 1) / CORE_CLK_PS);

  // ==========================================================================
  // per-bank event toggles crossing from link to core
  localparam int EV_ACT = 0;
  localparam int EV_PREF = 1;
  localparam int EV_DUE = 2;
  localparam int EV_PRE = 3;
  localparam int EV_NUM = 4;

endpackage

// ---- hdl/drp_bank_timer.sv ----
// per-bank row timing in the core clock domain
`timescale 1ns/10ps
module drp_bank_timer import drp_pkg::*; (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // event toggles from the link domain
  input wire logic [EV_NUM-1:0] ev_tgl_i,
  // bank state
  output logic row_open_o,
  output logic precharging_o,
  output logic ap_start_o
);

  // ==========================================================================
  // toggle synchronisers
  logic [EV_NUM-1:0] ev_meta;
  logic [EV_NUM-1:0] ev_sync;
  logic [EV_NUM-1:0] ev_last;
  logic [7:0] ras_cnt;
  logic [7:0] rtp_cnt;
  logic [7:0] rp_cnt;
  logic ap_pend;
  logic row_open;

  // meta stage is read by the sync stage only
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ev_meta <= '0;
      ev_sync <= '0;
      ev_last <= '0;
    end else begin
      ev_meta <= ev_tgl_i;
      ev_sync <= ev_meta;
      ev_last <= ev_sync;
    end
  end

  // one-cycle event pulses
  wire [EV_NUM-1:0] ev = ev_sync ^ ev_last;
  wire act_evt = ev[EV_ACT];
  wire pref_evt = ev[EV_PREF];
  wire due_evt = ev[EV_DUE];
  wire pre_evt = ev[EV_PRE];

  // ==========================================================================
  // start decision: both minimum times must have run out
  wire ras_ok = (ras_cnt == 8'h00);
  wire rtp_ok = (rtp_cnt == 8'h00);
  wire ap_start = ap_pend && ras_ok && rtp_ok;
  wire rp_busy = (rp_cnt != 8'h00);

  // row-active and read-to-precharge counters
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ras_cnt <= 8'h00;
      rtp_cnt <= 8'h00;
    end else begin
      ras_cnt <= act_evt ? RAS_CYC : (ras_ok ? ras_cnt : ras_cnt - 8'h01);
      // counted from the last prefetch edge, never earlier
      rtp_cnt <= pref_evt ? RTP_CYC : (rtp_ok ? rtp_cnt : rtp_cnt - 8'h01);
    end
  end

  // pending auto precharge; a new due event wins over the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ap_pend <= 1'b0;
    end else if (due_evt) begin
      ap_pend <= 1'b1;
    end else if (ap_start) begin
      ap_pend <= 1'b0;
    end
  end

  // row precharge counted from the real start, not a later edge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rp_cnt <= 8'h00;
    end else if (ap_start || pre_evt) begin
      rp_cnt <= RP_CYC;
    end else if (rp_busy) begin
      rp_cnt <= rp_cnt - 8'h01;
    end
  end

  // row state; an activate wins over a closing precharge
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      row_open <= 1'b0;
    end else if (act_evt) begin
      row_open <= 1'b1;
    end else if (ap_start || pre_evt) begin
      row_open <= 1'b0;
    end
  end

  assign row_open_o = row_open;
  assign precharging_o = rp_busy;
  assign ap_start_o = ap_start;

  // ==========================================================================
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_due_ready;
    due_evt && ras_ok && rtp_ok && !pref_evt && !act_evt;
  endsequence

  chk_ap_waits_ras: assert property (
    !ras_ok |-> !ap_start) else $error("precharge began before tRAS");
  chk_ap_waits_rtp: assert property (
    pref_evt |=> !ap_start [*2]) else $error("precharge too soon");
  chk_ap_on_time: assert property (
    s_due_ready |=> ap_start) else $error("auto precharge late");
  chk_rp_from_start: assert property (
    ap_start |=> precharging_o [*2]) else $error("tRP not from start");
  chk_row_closes: assert property (
    ap_start && !act_evt |=> !row_open_o) else $error("row stayed open");

endmodule // drp_bank_timer

// ---- hdl/drp_read_ap.sv ----
// ddr2 device read path with auto precharge and bank timing
`timescale 1ns/10ps
module drp_read_ap import drp_pkg::*; (
  // core clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // link clock from the controller
  input wire logic link_clk_i,
  // command pins, sampled on the link clock
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [BA_W-1:0] ba_i,
  input wire logic [ADDR_W-1:0] addr_i,
  // mode straps, static in operation
  input wire logic [2:0] al_i,
  input wire logic [2:0] cl_i,
  input wire logic bl8_i,
  // read data, rising and falling element of each link clock
  output logic [DQ_W-1:0] dq_rise_o,
  output logic [DQ_W-1:0] dq_fall_o,
  output logic dq_lo_oe_n_o,
  output logic dq_hi_oe_n_o,
  // byte strobes
  output logic lower_byte_strobe_o,
  output logic lower_byte_strobe_oe_n_o,
  output logic upper_byte_strobe_o,
  output logic upper_byte_strobe_oe_n_o,
  // bank state in the core domain
  output logic [NUM_BANKS-1:0] bank_open_o,
  output logic [NUM_BANKS-1:0] bank_precharging_o,
  output logic [NUM_BANKS-1:0] ap_start_o
);

  // ==========================================================================
  // link-domain reset and strap synchronisers
  logic lrst_meta;
  logic lrst;
  logic [6:0] mode_meta;
  logic [6:0] mode_sync;
  logic [NUM_BANKS-1:0] busy_meta;
  logic [NUM_BANKS-1:0] busy_sync;

  // straps are static in use, so the multi-bit copy needs no handshake;
  // precharge flags arrive two link edges late, a read may be dropped
  always_ff @(posedge link_clk_i) begin
    lrst_meta <= rst_i;
    lrst <= lrst_meta;
    mode_meta <= {bl8_i, cl_i, al_i};
    mode_sync <= mode_meta;
    busy_meta <= bank_precharging_o;
    busy_sync <= busy_meta;
  end

  // ==========================================================================
  // mode derived figures
  wire [3:0] al_s = {1'b0, mode_sync[2:0]};
  wire [3:0] cl_s = {1'b0, mode_sync[5:3]};
  wire bl8_s = mode_sync[6];
  wire [3:0] half_bl = bl8_s ? HALF_BL8 : HALF_BL4;
  wire [3:0] rl = al_s + cl_s;
  // index so the pipe empties at the read latency edge;
  // data then fills the cycle that opens at edge rl
  wire [3:0] rd_ins = rl - 4'h1;
  wire [3:0] ap_load = al_s + half_bl;
  wire [3:0] pref_load = al_s + (bl8_s ? PREF_EXTRA_BL8 : 4'h0);

  // ==========================================================================
  // command decode
  wire cmd_sel = !cs_n_i;
  wire is_read = cmd_sel && ras_n_i && !cas_n_i && we_n_i;
  wire is_act = cmd_sel && !ras_n_i && cas_n_i && we_n_i;
  wire is_pre = cmd_sel && !ras_n_i && cas_n_i && !we_n_i;
  wire ap_req = addr_i[AP_BIT];
  wire [BA_W-1:0] rd_bank = ba_i;
  // a read into a precharging bank is dropped
  wire rd_ok = is_read && !busy_sync[rd_bank];
  wire [COL_W-1:0] rd_col = addr_i[COL_W-1:0];
  // other commands pass unchecked; their spacing is the controller's job

  // ==========================================================================
  // read latency pipe
  logic [PIPE_DEPTH-1:0] rd_pipe;
  logic [COL_W-1:0] col_pipe [PIPE_DEPTH];
  logic [3:0] burst_left;
  logic [COL_W-1:0] elem_col;

  // delay line; bit 0 is high in the preamble cycle
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      rd_pipe <= '0;
    end else begin
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        rd_pipe[i] <= (rd_ok && rd_ins == 4'(i)) ||
          (i < PIPE_DEPTH - 1 && rd_pipe[(i + 1) % PIPE_DEPTH]);
      end
    end
  end

  // column travels beside its valid bit
  always_ff @(posedge link_clk_i) begin
    for (int i = 0; i < PIPE_DEPTH; i++) begin
      if (rd_ok && rd_ins == 4'(i)) begin
        col_pipe[i] <= rd_col;
      end else if (i < PIPE_DEPTH - 1) begin
        col_pipe[i] <= col_pipe[(i + 1) % PIPE_DEPTH];
      end
    end
  end

  // burst engine; a new burst joins the old one without a gap
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      burst_left <= 4'h0;
      elem_col <= '0;
    end else if (rd_pipe[0]) begin
      burst_left <= half_bl;
      elem_col <= col_pipe[0];
    end else if (burst_left != 4'h0) begin
      burst_left <= burst_left - 4'h1;
      elem_col <= elem_col + COL_W'(2);
    end
  end

  // ==========================================================================
  // data and strobes; each byte lane follows its own strobe
  wire data_on = (burst_left != 4'h0);
  wire preamble = rd_pipe[0] && !data_on;
  wire lane_oe_n = !data_on;
  assign dq_rise_o = {{(DQ_W-COL_W){1'b0}}, elem_col};
  assign dq_fall_o = {{(DQ_W-COL_W){1'b0}}, elem_col + COL_W'(1)};
  assign dq_lo_oe_n_o = lane_oe_n;
  assign dq_hi_oe_n_o = lane_oe_n;
  assign lower_byte_strobe_o = data_on;
  assign upper_byte_strobe_o = data_on;
  assign lower_byte_strobe_oe_n_o = !(data_on || preamble);
  assign upper_byte_strobe_oe_n_o = !(data_on || preamble);

  // ==========================================================================
  // per-bank link counters and event toggles
  logic [3:0] ap_cnt [NUM_BANKS];
  logic [3:0] pref_cnt [NUM_BANKS];
  logic [EV_NUM-1:0] ev_tgl [NUM_BANKS];

  // one counter pair per bank, so banks never share timing state
  for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
    wire hit = rd_ok && (rd_bank == BA_W'(b));
    wire act_hit = is_act && (ba_i == BA_W'(b));
    wire pre_hit = is_pre && (ap_req || ba_i == BA_W'(b));
    // last prefetch edge, possibly the read edge itself
    wire pref_fire = hit ? (pref_load == 4'h0) : (pref_cnt[b] == 4'h1);
    // banks run independently, so other banks keep working
    wire due_fire = !hit && (ap_cnt[b] == 4'h1);

    always_ff @(posedge link_clk_i) begin
      if (lrst) begin
        ap_cnt[b] <= 4'h0;
        pref_cnt[b] <= 4'h0;
      end else if (hit) begin
        ap_cnt[b] <= ap_req ? ap_load : 4'h0;
        pref_cnt[b] <= pref_load;
      end else begin
        ap_cnt[b] <= (ap_cnt[b] != 4'h0) ? ap_cnt[b] - 4'h1 : 4'h0;
        pref_cnt[b] <= (pref_cnt[b] != 4'h0) ? pref_cnt[b] - 4'h1 : 4'h0;
      end
    end

    // toggles carry single events across to the core clock
    always_ff @(posedge link_clk_i) begin
      if (lrst) begin
        ev_tgl[b] <= '0;
      end else begin
        ev_tgl[b][EV_ACT] <= ev_tgl[b][EV_ACT] ^ act_hit;
        ev_tgl[b][EV_PREF] <= ev_tgl[b][EV_PREF] ^ pref_fire;
        ev_tgl[b][EV_DUE] <= ev_tgl[b][EV_DUE] ^ due_fire;
        ev_tgl[b][EV_PRE] <= ev_tgl[b][EV_PRE] ^ pre_hit;
      end
    end

    // row-active, read-to-precharge and row precharge in core cycles
    drp_bank_timer u_timer (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .ev_tgl_i(ev_tgl[b]),
      .row_open_o(bank_open_o[b]),
      .precharging_o(bank_precharging_o[b]),
      .ap_start_o(ap_start_o[b])
    );

    // per-bank checks on the link clock
    chk_ap_due_time: assert property (
      @(posedge link_clk_i) disable iff (lrst)
      hit && ap_req |=> (ap_cnt[b] == ap_load))
      else $error("auto precharge count wrong");
    chk_ap_two_after: assert property (
      @(posedge link_clk_i) disable iff (lrst)
      pref_fire && !hit |=> !due_fire ##1 due_fire || ap_cnt[b] == 4'h0)
      else $error("precharge not two clocks after prefetch");
    chk_open_keeps: assert property (
      @(posedge link_clk_i) disable iff (lrst)
      hit && !ap_req |=> (ap_cnt[b] == 4'h0))
      else $error("read without ap started precharge");
  end

  // ==========================================================================
  // link-side checks
  sequence s_burst_start;
    rd_pipe[0] ##1 data_on;
  endsequence

  chk_burst_follows: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    rd_pipe[0] |-> s_burst_start) else $error("burst missed its edge");
  chk_strobe_lanes: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    !dq_lo_oe_n_o |-> !lower_byte_strobe_oe_n_o && lower_byte_strobe_o)
    else $error("lower lane without strobe");
  chk_preamble_low: assert property (
    @(posedge link_clk_i) disable iff (lrst)
    preamble |-> !upper_byte_strobe_oe_n_o && !upper_byte_strobe_o)
    else $error("preamble not low");

endmodule // drp_read_ap

// ---- test/drp_ctrl_model.sv ----
// controller model issuing ddr2 commands while keeping bank timing
`timescale 1ns/10ps
module drp_ctrl_model import drp_pkg::*; (
  // link clock and straps the device also sees
  input wire logic link_clk_i,
  input wire logic [2:0] al_i,
  input wire logic bl8_i,
  // command pins toward the device
  output logic cs_n_o,
  output logic ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [BA_W-1:0] ba_o,
  output logic [ADDR_W-1:0] addr_o
);
  // ==========================================================================
  // timing in link clocks, analog times rounded up
  localparam int LINK_PS = 80000;
  localparam int RTP_L = (T_RTP_PS + LINK_PS - 1) / LINK_PS;
  localparam int RP_L = (T_RP_PS + LINK_PS - 1) / LINK_PS;
  localparam int RAS_L = (T_RAS_PS + LINK_PS - 1) / LINK_PS;
  localparam int APACT_L = (T_RTP_PS + T_RP_PS + LINK_PS - 1) / LINK_PS;
  localparam logic [2:0] OP_ACT = 3'b011;
  localparam logic [2:0] OP_RD = 3'b101;

  // per-bank earliest edges; any_ok spaces other banks after auto precharge
  int cyc = 0;
  int same_ok [NUM_BANKS] = '{default: 0};
  int pre_ok [NUM_BANKS] = '{default: 0};
  int any_ok = 0;

  // link edge count; a command is taken on edge cyc
  always @(posedge link_clk_i) cyc <= cyc + 1;

  // start deselected
  initial begin
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hf;
    ba_o = '0;
    addr_o = '0;
  end

  // hold a command back until it is legal, then one link cycle on the pins
  task automatic send(input logic [2:0] op, input int bk,
                      input logic [ADDR_W-1:0] a);
    int c;
    int t;
    int half;
    int gate;
    // one idle edge after the last release, so no line is set twice at once
    @(posedge link_clk_i);
    #1;
    half = bl8_i ? 4 : 2;
    gate = (op == 3'b010) ? pre_ok[bk] : same_ok[bk];
    if (op == 3'b010 && a[AP_BIT])
      foreach (pre_ok[i]) if (pre_ok[i] > gate) gate = pre_ok[i];
    if (any_ok > gate) gate = any_ok;
    while (cyc + 1 < gate) begin
      @(posedge link_clk_i);
      #1;
    end
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = {1'b0, op};
    ba_o = bk[BA_W-1:0];
    addr_o = a;
    @(posedge link_clk_i);
    #1;
    c = cyc;
    // released lines are inverted so a stale value never looks valid
    cs_n_o = 1'b1;
    ba_o = ~ba_o;
    addr_o = ~addr_o;
    case (op)
      OP_ACT: begin
        same_ok[bk] = c + 1;
        pre_ok[bk] = c + RAS_L;
      end
      OP_RD: if (!a[AP_BIT]) begin
        same_ok[bk] = c + half;
        t = c + al_i + half - 2 + ((RTP_L > 2) ? RTP_L : 2);
        if (t > pre_ok[bk]) pre_ok[bk] = t;
      end else begin
        t = c + al_i + half - 2 + APACT_L;
        // short analog times: the precharge itself starts at AL + BL/2
        if (t < c + al_i + half + RP_L) t = c + al_i + half + RP_L;
        same_ok[bk] = t;
        pre_ok[bk] = t;
        any_ok = c + half;
      end
      default: begin
        for (int i = 0; i < NUM_BANKS; i++)
          if (i == bk || a[AP_BIT]) same_ok[i] = c + RP_L;
      end
    endcase
  endtask
endmodule // drp_ctrl_model

// ---- test/drp_read_ap_test.sv ----
// self-checking bench for the ddr2 read and auto precharge block
`timescale 1ns/10ps
module drp_read_ap_test import drp_pkg::*; ;
  localparam logic [2:0] OP_ACT = 3'b011;
  localparam logic [2:0] OP_RD = 3'b101;
  localparam logic [2:0] OP_PRE = 3'b010;
  logic core_clk = 1'b0;
  logic link_clk = 1'b0;
  logic rst = 1'b1;
  logic cs_n, ras_n, cas_n, we_n;
  logic [BA_W-1:0] ba;
  logic [ADDR_W-1:0] addr;
  logic [2:0] al = 3'h1;
  logic [2:0] cl = 3'h3;
  logic bl8 = 1'b0;
  logic [DQ_W-1:0] dq_rise, dq_fall;
  logic lo_oe_n, hi_oe_n, lo_stb, lo_stb_oe_n, hi_stb, hi_stb_oe_n;
  logic [NUM_BANKS-1:0] open_b, pch_b, ap_b;
  logic [NUM_BANKS-1:0] open_q = '0;
  int bad_count = 0;
  int checks = 0;
  int ccyc = 0;
  int ap_count [NUM_BANKS] = '{default: 0};
  int ap_lcyc [NUM_BANKS] = '{default: 0};
  int ap_c [NUM_BANKS] = '{default: 0};
  int open_c [NUM_BANKS] = '{default: 0};
  int pch_run [NUM_BANKS] = '{default: 0};
  int pch_len [NUM_BANKS] = '{default: 0};

  // ==========================================================================
  // clocks; rising edges of the two never coincide
  always #5 core_clk = ~core_clk;
  always #40 link_clk = ~link_clk;

  drp_read_ap u_drp_read_ap (
    .core_clk_i(core_clk), .rst_i(rst), .link_clk_i(link_clk),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n),
    .ba_i(ba), .addr_i(addr), .al_i(al), .cl_i(cl), .bl8_i(bl8),
    .dq_rise_o(dq_rise), .dq_fall_o(dq_fall),
    .dq_lo_oe_n_o(lo_oe_n), .dq_hi_oe_n_o(hi_oe_n),
    .lower_byte_strobe_o(lo_stb), .lower_byte_strobe_oe_n_o(lo_stb_oe_n),
    .upper_byte_strobe_o(hi_stb), .upper_byte_strobe_oe_n_o(hi_stb_oe_n),
    .bank_open_o(open_b), .bank_precharging_o(pch_b), .ap_start_o(ap_b)
  );

  drp_ctrl_model u_drp_ctrl_model (
    .link_clk_i(link_clk), .al_i(al), .bl8_i(bl8),
    .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .ba_o(ba), .addr_o(addr)
  );

  // ==========================================================================
  // bank event log in core cycles; also cuts a hang short
  always @(posedge core_clk) begin
    ccyc <= ccyc + 1;
    open_q <= open_b;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (open_b[b] === 1'b1 && open_q[b] === 1'b0) open_c[b] = ccyc;
      if (ap_b[b] === 1'b1) begin
        ap_count[b]++;
        ap_c[b] = ccyc;
        ap_lcyc[b] = u_drp_ctrl_model.cyc;
      end
      if (pch_b[b] === 1'b1) pch_run[b]++;
      else if (pch_run[b] != 0) begin
        pch_len[b] = pch_run[b];
        pch_run[b] = 0;
      end
    end
    if (ccyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_link(input int n);
    repeat (n) begin
      @(posedge link_clk);
      #1;
    end
  endtask

  // open a row, read one burst and follow preamble, lanes and columns
  task automatic t_burst(input logic [2:0] a, input logic [2:0] c,
                         input logic b8, input int bk,
                         input logic [COL_W-1:0] col);
    int rl;
    int half;
    logic drv;
    logic pre;
    logic [COL_W-1:0] e;
    rl = a + c;
    half = b8 ? 4 : 2;
    wait_link(1);
    al = a;
    cl = c;
    bl8 = b8;
    wait_link(2);
    u_drp_ctrl_model.send(OP_ACT, bk, '0);
    u_drp_ctrl_model.send(OP_RD, bk, {4'h0, col});
    for (int k = 1; k <= rl + half; k++) begin
      @(posedge link_clk);
      #20;
      drv = (k >= rl && k < rl + half);
      pre = (k >= rl - 1 && k < rl + half);
      e = col + COL_W'(2 * (k - rl));
      check("data lane enables", {lo_oe_n, hi_oe_n}, {2{!drv}});
      check("strobe enables", {lo_stb_oe_n, hi_stb_oe_n}, {2{!pre}});
      if (pre) check("strobe level", {lo_stb, hi_stb}, {2{drv}});
      if (drv) check("rise data", dq_rise, {6'h0, e});
      if (drv) check("fall data", dq_fall, {6'h0, e + 10'h001});
    end
  endtask

  // read with auto precharge while bank 0 stays open, then reopen
  task automatic t_autopre(input logic [2:0] a, input logic b8,
                           input int bk);
    int c;
    int n;
    int half;
    half = b8 ? 4 : 2;
    wait_link(1);
    al = a;
    bl8 = b8;
    wait_link(2);
    u_drp_ctrl_model.send(OP_ACT, bk, '0);
    n = ap_count[bk];
    u_drp_ctrl_model.send(OP_RD, bk, 14'h0400);
    c = u_drp_ctrl_model.cyc;
    repeat (800) if (ap_count[bk] == n) @(posedge core_clk);
    repeat (10) @(posedge core_clk);
    check("auto precharge pulses", ap_count[bk] - n, 1);
    check("start link edge", ap_lcyc[bk] - c, a + half);
    check("row active kept", ap_c[bk] - open_c[bk] >= RAS_CYC, 1);
    check("row precharge cycles", pch_len[bk], RP_CYC);
    check("row closed", open_b[bk], 0);
    check("other bank open", open_b[0], 1);
    wait_link(1);
    u_drp_ctrl_model.send(OP_ACT, bk, '0);
    wait_link(1);
    check("row reopened", open_b[bk], 1);
  endtask

  // explicit precharge of one bank, then of all banks
  task automatic t_precharge;
    wait_link(1);
    u_drp_ctrl_model.send(OP_ACT, 6, '0);
    u_drp_ctrl_model.send(OP_RD, 6, 14'h0010);
    u_drp_ctrl_model.send(OP_PRE, 6, '0);
    wait_link(1);
    check("no auto precharge", ap_count[6], 0);
    check("bank closed", open_b[6], 0);
    check("row precharge cycles", pch_len[6], RP_CYC);
    check("other bank open", open_b[0], 1);
    u_drp_ctrl_model.send(OP_PRE, 0, 14'h0400);
    wait_link(1);
    check("all banks closed", open_b, 0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (20) @(posedge core_clk);
    wait_link(3);
    check("lanes idle in reset",
          {lo_oe_n, hi_oe_n, lo_stb_oe_n, hi_stb_oe_n}, 4'hf);
    @(posedge core_clk);
    #1;
    rst = 1'b0;
    wait_link(4);
    t_burst(3'h1, 3'h3, 1'b0, 0, 10'h004);
    t_burst(3'h0, 3'h2, 1'b1, 1, 10'h3fc);
    t_burst(3'h2, 3'h4, 1'b0, 2, 10'h1fe);
    t_autopre(3'h1, 1'b0, 4);
    t_autopre(3'h0, 1'b1, 5);
    t_precharge();
    close_out();
  end
endmodule // drp_read_ap_test
